// ===== inc/lprm_pkg.sv
// package for the load protection, ramp and mode register bank
package lprm_pkg;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] data;
    } lprm_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  exc;
        logic [15:0] data;
    } lprm_rsp_t;

    // ------------------------------------------------------------------
    // function and exception codes
    // ------------------------------------------------------------------
    localparam logic [7:0] FC_READ    = 8'h03;
    localparam logic [7:0] FC_WRITE1  = 8'h06;
    localparam logic [7:0] FC_WRITEN  = 8'h10;
    localparam logic [7:0] EXC_NONE   = 8'h00;
    localparam logic [7:0] EXC_FUNC   = 8'h01;
    localparam logic [7:0] EXC_ADDR   = 8'h02;
    localparam logic [7:0] EXC_DATA   = 8'h03;

    // ------------------------------------------------------------------
    // float settings: 0 ov, 1 op, 2 uv, 3..5 rise i/v/p, 6..8 fall i/v/p
    // ------------------------------------------------------------------
    localparam int          NFLT      = 9;
    localparam logic [3:0]  FIRST_SLEW = 4'h3;
    localparam logic [15:0] FLT_WR_ADDR [NFLT] = '{16'h4030, 16'h4050, 16'h4070,
        16'h5010, 16'h5030, 16'h5050, 16'h5090, 16'h50b0, 16'h50d0};
    localparam logic [15:0] FLT_RD_ADDR [NFLT] = '{16'h4040, 16'h4060, 16'h4080,
        16'h5020, 16'h5040, 16'h5060, 16'h50a0, 16'h50c0, 16'h50e0};

    // ------------------------------------------------------------------
    // 16-bit settings
    // ------------------------------------------------------------------
    localparam logic [15:0] MODE_WR_ADDR   = 16'h6030;
    localparam logic [15:0] MODE_RD_ADDR   = 16'h6040;
    localparam logic [15:0] RELOAD_WR_ADDR = 16'h8010;
    localparam logic [15:0] LOCK_RD_ADDR   = 16'h8020;
    localparam logic [15:0] LOCK_WR_ADDR   = 16'h8030;
    localparam logic [15:0] SENSE_WR_ADDR  = 16'h8060;
    localparam logic [15:0] SENSE_RD_ADDR  = 16'h8070;
    localparam logic [15:0] ORIGIN_WR_ADDR = 16'h80a0;
    localparam logic [15:0] ORIGIN_RD_ADDR = 16'h80b0;

    // regulation modes, reload kinds and setpoint origins
    localparam logic [2:0] MODE_CURRENT    = 3'h1;
    localparam logic [2:0] MODE_VOLTAGE    = 3'h2;
    localparam logic [2:0] MODE_POWER      = 3'h3;
    localparam logic [2:0] MODE_SHUNT      = 3'h6;
    localparam logic [1:0] RELOAD_SOFT     = 2'h1;
    localparam logic [1:0] RELOAD_HARD     = 2'h2;
    localparam logic [1:0] ORIGIN_LOCAL    = 2'h0;
    localparam logic [1:0] ORIGIN_ANALOG   = 2'h2;

    // ------------------------------------------------------------------
    // reset values, slew limits, special codes, timing
    // ------------------------------------------------------------------
    localparam logic [31:0] OV_RESET    = 32'h461c4000; // 10000.0
    localparam logic [31:0] OP_RESET    = 32'h47c35000; // 100000.0
    localparam logic [31:0] UV_RESET    = 32'h00000000; // 0.0
    localparam logic [31:0] SLEW_MIN    = 32'h3f800000; // 1.0 per ms
    localparam logic [31:0] SLEW_MAX    = 32'h447a0000; // 1000.0 per ms
    localparam logic [31:0] CODE_MAX    = 32'h7f800000; // +inf asks for max
    localparam logic [31:0] CODE_MIN    = 32'hff800000; // -inf asks for min
    localparam logic [2:0]  MODE_RESET  = 3'h2;
    localparam logic [2:0]  TRIP_SAMPLES = 3'h3;
    localparam logic [7:0]  STOP_MASK   = 8'h01;        // stop button is bit 0
endpackage : lprm_pkg

// ===== src/lprm_regs.sv
// register bank for protection trips, slew rates and operating modes
// Notes on behaviour
// R1 - ov threshold: two-word write, separate query address
// R2 - sustained overvoltage disconnects input, flags fault
// R3 - sustained overpower disconnects input, flags fault
// R4 - sustained undervoltage disconnects input, flags fault
// R5 - max code fastest slew, min code slowest
// R6 - slew below minimum stored as minimum
// R7 - current slew above maximum stored as maximum
// R8 - rising current slew, constant current mode
// R9 - rising voltage slew, constant voltage mode
// R10 - rising power slew, constant power mode
// R11 - falling current slew, constant current mode
// R12 - falling voltage slew, constant voltage mode
// R13 - falling power slew, constant power mode
// R14 - mode single write codes one to six
// R15 - reload defaults, one soft, two hard
// R16 - lock flag written high, read lower address
// R17 - locked panel passes only stop button
// R18 - sense location local or remote
// R19 - sense choice feeds power and resistance
// R20 - setpoint origin local, generator or analog
// R21 - origin defaults to local after reset/reload
// R22 - float high word first, both before effect
// R23 - bad enumeration value rejected, setting kept
module lprm_regs (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    // register requests and answers
    input  wire lprm_pkg::lprm_req_t req_i,
    output lprm_pkg::lprm_rsp_t     rsp_o,
    // measurements
    input  wire logic               sample_valid_i,
    input  wire logic [31:0]        volt_local_i,
    input  wire logic [31:0]        volt_remote_i,
    input  wire logic [31:0]        power_i,
    input  wire logic               fault_clear_i,
    // front panel
    input  wire logic [7:0]         panel_btn_i,
    output logic [7:0]              panel_btn_o,
    // protection
    output logic                    input_disconnect_o,
    output logic                    overvoltage_fault_o,
    output logic                    overpower_fault_o,
    output logic                    undervoltage_fault_o,
    // settings to the controller
    output logic [31:0]             calc_volt_o,
    output logic [2:0]              regulation_mode_o,
    output logic                    sense_location_o,
    output logic [1:0]              setpoint_origin_o,
    output logic                    panel_lock_o,
    output logic [31:0]             rise_slew_o,
    output logic [31:0]             fall_slew_o,
    output logic [1:0]              defaults_reload_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // ieee single compare a > b; nan is not expected on these paths
    function automatic logic fgt(input logic [31:0] a, input logic [31:0] b);
        if (a[31] != b[31])
            fgt = !a[31] && ((a[30:0] != 31'h0) || (b[30:0] != 31'h0));
        else if (!a[31])
            fgt = a[30:0] > b[30:0];
        else
            fgt = a[30:0] < b[30:0];
    endfunction

    // table search: {hit, index}; off selects the low word address
    function automatic logic [4:0] find(input logic [15:0] a,
                                        input logic [15:0] tbl [lprm_pkg::NFLT],
                                        input logic [15:0] off);
        find = 5'h00;
        for (int i = 0; i < lprm_pkg::NFLT; i++) begin
            if (a == tbl[i] + off)
                find = {1'b1, 4'(i)};
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0]         flt_r [lprm_pkg::NFLT];
    logic [15:0]         pend_hi_r;
    logic [3:0]          pend_idx_r;
    logic                pend_vld_r;
    logic [2:0]          mode_r;
    logic                lock_r;
    logic                sense_r;
    logic [1:0]          origin_r;
    logic [2:0]          trip_cnt_r [3];
    logic [2:0]          fault_r;
    logic [2:0]          fault_nxt;
    logic                disc_r;
    lprm_pkg::lprm_rsp_t rsp_nxt;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    wire logic [4:0]  wr_hi_f = find(req_i.addr, lprm_pkg::FLT_WR_ADDR, 16'h0000);
    wire logic [4:0]  wr_lo_f = find(req_i.addr, lprm_pkg::FLT_WR_ADDR, 16'h0001);
    wire logic [4:0]  rd_hi_f = find(req_i.addr, lprm_pkg::FLT_RD_ADDR, 16'h0000);
    wire logic [4:0]  rd_lo_f = find(req_i.addr, lprm_pkg::FLT_RD_ADDR, 16'h0001);
    wire logic        is_rd   = req_i.valid && (req_i.func == lprm_pkg::FC_READ);
    wire logic        is_w1   = req_i.valid && (req_i.func == lprm_pkg::FC_WRITE1);
    wire logic        is_wn   = req_i.valid && (req_i.func == lprm_pkg::FC_WRITEN);
    wire logic [15:0] d       = req_i.data;
    // enumeration legality per target
    wire logic        a_mode   = req_i.addr == lprm_pkg::MODE_WR_ADDR;
    wire logic        a_reload = req_i.addr == lprm_pkg::RELOAD_WR_ADDR;
    wire logic        a_lock   = req_i.addr == lprm_pkg::LOCK_WR_ADDR;
    wire logic        a_sense  = req_i.addr == lprm_pkg::SENSE_WR_ADDR;
    wire logic        a_origin = req_i.addr == lprm_pkg::ORIGIN_WR_ADDR;
    wire logic        a_enum   = a_mode || a_reload || a_lock || a_sense || a_origin;
    wire logic        ok_mode  = (d != 16'h0000) && (d <= 16'(lprm_pkg::MODE_SHUNT));
    wire logic        ok_rel   = (d == 16'(lprm_pkg::RELOAD_SOFT))
                              || (d == 16'(lprm_pkg::RELOAD_HARD));
    wire logic        ok_bool  = d <= 16'h0001;
    wire logic        ok_orig  = d <= 16'(lprm_pkg::ORIGIN_ANALOG);
    wire logic        enum_ok  = (a_mode && ok_mode) || (a_reload && ok_rel)
                              || ((a_lock || a_sense) && ok_bool) || (a_origin && ok_orig); // R23
    wire logic        lo_match = pend_vld_r && (pend_idx_r == wr_lo_f[3:0]);

    // ------------------------------------------------------------------
    // answer: one word per request, exception when not accepted
    // ------------------------------------------------------------------
    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.valid = req_i.valid;
        if (is_rd) begin
            if (rd_hi_f[4])
                rsp_nxt.data = flt_r[rd_hi_f[3:0]][31:16];
            else if (rd_lo_f[4])
                rsp_nxt.data = flt_r[rd_lo_f[3:0]][15:0];
            else if (req_i.addr == lprm_pkg::MODE_RD_ADDR)
                rsp_nxt.data = 16'(mode_r);                          // R14
            else if (req_i.addr == lprm_pkg::LOCK_RD_ADDR)
                rsp_nxt.data = 16'(lock_r);                          // R16
            else if (req_i.addr == lprm_pkg::SENSE_RD_ADDR)
                rsp_nxt.data = 16'(sense_r);                         // R18
            else if (req_i.addr == lprm_pkg::ORIGIN_RD_ADDR)
                rsp_nxt.data = 16'(origin_r);                        // R20
            else
                rsp_nxt.exc = lprm_pkg::EXC_ADDR;
        end else if (is_w1) begin
            if (a_enum)
                rsp_nxt.exc = enum_ok ? lprm_pkg::EXC_NONE : lprm_pkg::EXC_DATA; // R23
            else if (wr_hi_f[4] || wr_lo_f[4])
                rsp_nxt.exc = lprm_pkg::EXC_FUNC;
            else
                rsp_nxt.exc = lprm_pkg::EXC_ADDR;
        end else if (is_wn) begin
            if (wr_lo_f[4] && !lo_match)
                rsp_nxt.exc = lprm_pkg::EXC_DATA;                    // R22
            else if (!wr_hi_f[4] && !wr_lo_f[4])
                rsp_nxt.exc = lprm_pkg::EXC_ADDR;
        end else if (req_i.valid) begin
            rsp_nxt.exc = lprm_pkg::EXC_FUNC;
        end
    end

    // accepted writes
    wire logic        acc      = rsp_nxt.valid && (rsp_nxt.exc == lprm_pkg::EXC_NONE);
    wire logic        w_hi     = acc && is_wn && wr_hi_f[4];
    wire logic        w_lo     = acc && is_wn && wr_lo_f[4];            // R22
    wire logic        w_enum   = acc && is_w1;
    wire logic        reload   = w_enum && a_reload;                   // R15
    wire logic        hard     = reload && (d[1:0] == lprm_pkg::RELOAD_HARD);

    // slew clamp: codes and out-of-range values land on the limits
    wire logic [31:0] flt_in   = {pend_hi_r, d};
    wire logic        is_slew  = wr_lo_f[3:0] >= lprm_pkg::FIRST_SLEW;
    wire logic [31:0] flt_put  = !is_slew ? flt_in :
                                 fgt(lprm_pkg::SLEW_MIN, flt_in) ? lprm_pkg::SLEW_MIN : // R5 R6
                                 fgt(flt_in, lprm_pkg::SLEW_MAX) ? lprm_pkg::SLEW_MAX : // R5 R7
                                 flt_in;

    // ------------------------------------------------------------------
    // float settings and pending high word
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_hi_r  <= 16'h0000;
            pend_idx_r <= 4'h0;
            pend_vld_r <= 1'b0;
        end else begin
            if (w_hi) begin
                pend_hi_r  <= d;
                pend_idx_r <= wr_hi_f[3:0];
            end
            pend_vld_r <= w_hi || (pend_vld_r && !w_lo && !reload);  // R22
        end
    end

    // reload sets every float back to its reset value
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flt_r <= '{lprm_pkg::OV_RESET, lprm_pkg::OP_RESET, lprm_pkg::UV_RESET,
                       lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX,
                       lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX};
        end else if (reload) begin
            flt_r <= '{lprm_pkg::OV_RESET, lprm_pkg::OP_RESET, lprm_pkg::UV_RESET,
                       lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX,
                       lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX, lprm_pkg::SLEW_MAX}; // R15
        end else if (w_lo) begin
            flt_r[wr_lo_f[3:0]] <= flt_put;                          // R1 R3 R4 R8
        end
    end

    // ------------------------------------------------------------------
    // enumerated settings
    // ------------------------------------------------------------------
    // soft reload keeps the lock so a locked panel stays locked
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_r   <= lprm_pkg::MODE_RESET;
            lock_r   <= 1'b0;
            sense_r  <= 1'b0;
            origin_r <= lprm_pkg::ORIGIN_LOCAL;
        end else if (reload) begin
            mode_r   <= lprm_pkg::MODE_RESET;
            lock_r   <= hard ? 1'b0 : lock_r;
            sense_r  <= 1'b0;
            origin_r <= lprm_pkg::ORIGIN_LOCAL;                      // R21
        end else if (w_enum) begin
            if (a_mode)   mode_r   <= d[2:0];                        // R14
            if (a_lock)   lock_r   <= d[0];                          // R16
            if (a_sense)  sense_r  <= d[0];                          // R18
            if (a_origin) origin_r <= d[1:0];                        // R20
        end
    end

    // ------------------------------------------------------------------
    // protection trips: consecutive samples beyond threshold
    // ------------------------------------------------------------------
    wire logic [31:0] sel_volt = sense_r ? volt_remote_i : volt_local_i;  // R19
    wire logic [2:0]  beyond   = {fgt(flt_r[2], sel_volt),            // R4
                                  fgt(power_i, flt_r[1]),             // R3
                                  fgt(sel_volt, flt_r[0])};           // R2
    wire logic [2:0]  clr_f    = {3{fault_clear_i || hard}};

    // fault set wins over a clear in the same cycle
    always_comb begin
        fault_nxt = fault_r & ~clr_f;
        for (int k = 0; k < 3; k++) begin
            if (sample_valid_i && beyond[k] && (trip_cnt_r[k] == lprm_pkg::TRIP_SAMPLES - 3'h1))
                fault_nxt[k] = 1'b1;                                 // R2 R3 R4
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trip_cnt_r <= '{3'h0, 3'h0, 3'h0};
            fault_r    <= 3'h0;
            disc_r     <= 1'b0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (sample_valid_i)
                    trip_cnt_r[k] <= !beyond[k] ? 3'h0 :
                        (trip_cnt_r[k] == lprm_pkg::TRIP_SAMPLES) ? trip_cnt_r[k] :
                        trip_cnt_r[k] + 3'h1;
            end
            fault_r <= fault_nxt;
            disc_r  <= |fault_nxt;                                   // R2 R3 R4
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    wire logic [3:0] rise_idx = (mode_r == lprm_pkg::MODE_CURRENT) ? 4'h3 :
                                (mode_r == lprm_pkg::MODE_POWER)   ? 4'h5 : 4'h4; // R8 R9 R10
    wire logic [3:0] fall_idx = rise_idx + 4'h3;                     // R11 R12 R13
    wire logic [7:0] btn_gate = lock_r ? lprm_pkg::STOP_MASK : 8'hff; // R17

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_o             <= '0;
            panel_btn_o       <= 8'h00;
            calc_volt_o       <= 32'h00000000;
            rise_slew_o       <= lprm_pkg::SLEW_MAX;
            fall_slew_o       <= lprm_pkg::SLEW_MAX;
            defaults_reload_o <= 2'h0;
        end else begin
            rsp_o             <= rsp_nxt;
            panel_btn_o       <= panel_btn_i & btn_gate;             // R17
            calc_volt_o       <= sel_volt;                           // R19
            rise_slew_o       <= flt_r[rise_idx];
            fall_slew_o       <= flt_r[fall_idx];
            defaults_reload_o <= reload ? d[1:0] : 2'h0;             // R15
        end
    end

    // settings mirror their own flops
    assign regulation_mode_o    = mode_r;
    assign panel_lock_o         = lock_r;
    assign sense_location_o     = sense_r;
    assign setpoint_origin_o    = origin_r;
    assign overvoltage_fault_o  = fault_r[0];
    assign overpower_fault_o    = fault_r[1];
    assign undervoltage_fault_o = fault_r[2];
    assign input_disconnect_o   = disc_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_ov_hi;
        req_i.valid && req_i.func == lprm_pkg::FC_WRITEN && req_i.addr == 16'h4030;
    endsequence
    sequence s_ov_lo;
        req_i.valid && req_i.func == lprm_pkg::FC_WRITEN && req_i.addr == 16'h4031;
    endsequence

    ov_pair_write_a: assert property (s_ov_hi ##1 s_ov_lo |=>  // R1 R22
        flt_r[0] == {$past(req_i.data, 2), $past(req_i.data)})
        else $error("ov threshold not stored from word pair");
    lone_low_word_a: assert property (is_wn && wr_lo_f[4] && !pend_vld_r |=>  // R22
        rsp_o.exc == 8'h03) else $error("low word without high accepted");
    ov_trip_cause_a: assert property ($rose(overvoltage_fault_o) |->  // R2
        $past(sample_valid_i && beyond[0] && trip_cnt_r[0] == 3'h2))
        else $error("ov fault without sustained samples");
    fault_opens_a: assert property (fault_r != 3'h0 |-> input_disconnect_o)  // R3
        else $error("fault without disconnect");
    lock_panel_a: assert property (lock_r |=> panel_btn_o[7:1] == 7'h00 &&  // R17
        panel_btn_o[0] == $past(panel_btn_i[0])) else $error("locked panel leak");
    mode_reject_a: assert property (is_w1 && a_mode && d == 16'h0007 |=>  // R23
        rsp_o.exc == 8'h03 && $stable(regulation_mode_o))
        else $error("bad mode accepted");
    mode_write_a: assert property (is_w1 && a_mode && d == 16'h0003 |=>  // R14
        regulation_mode_o == 3'h3) else $error("mode write lost");
    slew_floor_a: assert property (w_lo && is_slew && fgt(32'h3f800000, flt_in) |=>  // R6
        flt_r[$past(wr_lo_f[3:0])] == 32'h3f800000) else $error("slew below min kept");
    slew_ceiling_a: assert property (w_lo && wr_lo_f[3:0] == 4'h3 && flt_in == 32'h7f800000
        |=> flt_r[3] == 32'h447a0000) else $error("max code not fastest");  // R5 R7
    sense_calc_a: assert property (##1 calc_volt_o ==  // R19
        $past(sense_r ? volt_remote_i : volt_local_i)) else $error("wrong sense volt");
    origin_reload_a: assert property (defaults_reload_o != 2'h0 |->  // R21
        setpoint_origin_o == 2'h0) else $error("origin not local after reload");

    // one answer per request, never one without
    answer_next_a: assert property (req_i.valid |=> rsp_o.valid)  // R1
        else $error("request without answer");
    answer_only_a: assert property (!req_i.valid |=> !rsp_o.valid)  // R1
        else $error("answer without request");

    // trips need a beyond sample and hold until cleared
    op_trip_cause_a: assert property ($rose(overpower_fault_o) |->  // R3
        $past(sample_valid_i && beyond[1])) else $error("op fault without sample");
    uv_trip_cause_a: assert property ($rose(undervoltage_fault_o) |->  // R4
        $past(sample_valid_i && beyond[2])) else $error("uv fault without sample");
    ov_sticky_a: assert property (fault_r[0] && !fault_clear_i && !hard |=>  // R2
        overvoltage_fault_o) else $error("ov fault dropped");

    // reload variants, slew routing, readback and rejects
    hard_unlock_a: assert property (hard |=> !panel_lock_o && defaults_reload_o == 2'h2)  // R15
        else $error("hard reload kept lock");
    soft_lock_a: assert property (reload && !hard |=> $stable(panel_lock_o))  // R15
        else $error("soft reload changed lock");
    rise_route_a: assert property (mode_r == 3'h1 |=> rise_slew_o == $past(flt_r[3]))  // R8
        else $error("current rise slew not routed");
    fall_route_a: assert property (mode_r == 3'h3 |=> fall_slew_o == $past(flt_r[8]))  // R13
        else $error("power fall slew not routed");
    lock_read_a: assert property (is_rd && req_i.addr == 16'h8020 |=>  // R16
        rsp_o.data == {15'h0000, $past(lock_r)}) else $error("lock readback wrong");
    origin_reject_a: assert property (is_w1 && a_origin && d == 16'h0003 |=>  // R23
        rsp_o.exc == 8'h03 && $stable(setpoint_origin_o)) else $error("bad origin kept");
endmodule // lprm_regs

// ===== verification/lprm_client.sv
// register client model that drives the bank's request port
module lprm_client (
    // clock
    input  wire logic                ref_clk_i,
    // requests and answers
    output lprm_pkg::lprm_req_t      req_o,
    input  wire lprm_pkg::lprm_rsp_t rsp_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned         gap = 0; // idle cycles before a request, slow client
    lprm_pkg::lprm_rsp_t last;    // answer to the latest request
    initial req_o = '0;
    // one word, held to its taking edge; released fields show inverted junk
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        repeat (gap) @(posedge ref_clk_i);
        req_o <= '{1'b1, f, a, d};
        @(posedge ref_clk_i);
        req_o <= '{1'b0, ~f, ~a, ~d};
        #1 last = rsp_i;
    endtask
    // float write as two word writes, high word first
    task automatic wrf(input logic [15:0] a, input logic [31:0] v);
        xfer(lprm_pkg::FC_WRITEN, a, v[31:16]);
        xfer(lprm_pkg::FC_WRITEN, a + 16'h1, v[15:0]);
    endtask
endmodule // lprm_client

// ===== verification/test_lprm_regs.sv
// self-checking bench for the protection, ramp and mode register bank
module test_lprm_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic                ref_clk_i = 1'b0;
    logic                arst_n_i  = 1'b0;
    lprm_pkg::lprm_req_t req;
    lprm_pkg::lprm_rsp_t rsp;
    logic                sv = 1'b0, fc = 1'b0, dis, ovf, opf, uvf, sense, lock;
    logic [31:0]         vl = '0, vr = '0, pw = '0, calc, rise, fall, v, x;
    logic [31:0]         ex [9];
    logic [7:0]          btn = '0, btn_o;
    logic [2:0]          mode;
    logic [1:0]          origin, reload;
    int                  fails = 0, checks = 0, seed = 32'h312173be;
    lprm_client u (.ref_clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));
    lprm_regs dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req), .rsp_o(rsp),
        .sample_valid_i(sv), .volt_local_i(vl), .volt_remote_i(vr), .power_i(pw),
        .fault_clear_i(fc), .panel_btn_i(btn), .panel_btn_o(btn_o), .input_disconnect_o(dis),
        .overvoltage_fault_o(ovf), .overpower_fault_o(opf), .undervoltage_fault_o(uvf),
        .calc_volt_o(calc), .regulation_mode_o(mode), .sense_location_o(sense),
        .setpoint_origin_o(origin), .panel_lock_o(lock), .rise_slew_o(rise),
        .fall_slew_o(fall), .defaults_reload_o(reload));
    // 25 MHz clock
    always #20 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdf(input logic [15:0] a, output logic [31:0] r);
        u.xfer(lprm_pkg::FC_READ, a, 16'h0);
        r[31:16] = u.last.data;
        u.xfer(lprm_pkg::FC_READ, a + 16'h1, 16'h0);
        r[15:0] = u.last.data;
    endtask
    // three consecutive samples, enough to trip
    task automatic samp(input logic [31:0] a, input logic [31:0] b);
        @(posedge ref_clk_i);
        sv <= 1'b1;
        vl <= a;
        pw <= b;
        repeat (3) @(posedge ref_clk_i);
        sv <= 1'b0;
        fc <= 1'b0;
        #1;
    endtask
    // expected stored slew: signs and small values go to min, large to max
    function automatic logic [31:0] exp_slew(input logic [31:0] w);
        if (w[31] || w < lprm_pkg::SLEW_MIN) return lprm_pkg::SLEW_MIN;
        if (w > lprm_pkg::SLEW_MAX) return lprm_pkg::SLEW_MAX;
        return w;
    endfunction
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #800us;
        fails++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        vr <= 32'h42f00000;
        chk(mode, 32'h2);
        rdf(16'h4040, v);
        chk(v, lprm_pkg::OV_RESET);
        for (int i = 3; i < 9; i++) begin
            for (int k = 0; k < 6; k++) begin
                u.gap = $unsigned($random(seed)) % 3;
                x = k == 0 ? 32'h7f800000 : k == 1 ? 32'hff800000 : k == 2 ? 32'h3f000000 :
                    k == 3 ? 32'h44fa0000 : {5'h08, 27'($random(seed))};
                u.wrf(lprm_pkg::FLT_WR_ADDR[i], x);
                ex[i] = exp_slew(x);
                rdf(lprm_pkg::FLT_RD_ADDR[i], v);
                chk(v, ex[i]);
            end
        end
        u.xfer(lprm_pkg::FC_WRITEN, 16'h4071, 16'h0);
        chk(u.last.exc, lprm_pkg::EXC_DATA);
        u.xfer(lprm_pkg::FC_READ, 16'h4030, 16'h0);
        chk(u.last.exc, lprm_pkg::EXC_ADDR);
        for (int m = 1; m < 8; m++) begin
            u.xfer(lprm_pkg::FC_WRITE1, 16'h6030, 16'(m));
            chk(u.last.exc, m == 7 ? lprm_pkg::EXC_DATA : lprm_pkg::EXC_NONE);
            chk(mode, m == 7 ? 6 : m);
            @(posedge ref_clk_i);
            #1;
            if (m < 4) chk(rise, ex[m + 2]);
            if (m < 4) chk(fall, ex[m + 5]);
        end
        u.gap = 0;
        u.wrf(16'h4030, 32'h42c80000);
        u.wrf(16'h4070, 32'h42480000);
        samp(32'h43480000, 32'h0);
        chk({ovf, uvf, opf, dis}, 4'b1001);
        @(posedge ref_clk_i) fc <= 1'b1;
        samp(32'h41200000, 32'h48000000);
        chk({ovf, uvf, opf, dis}, 4'b0111);
        u.xfer(lprm_pkg::FC_WRITE1, 16'h8060, 16'h1);
        @(posedge ref_clk_i);
        #1 chk(calc, 32'h42f00000);
        chk(sense, 32'h1);
        u.xfer(lprm_pkg::FC_WRITE1, 16'h8030, 16'h1);
        btn <= 8'hff;
        u.xfer(lprm_pkg::FC_READ, 16'h8020, 16'h0);
        chk({btn_o, u.last.data}, 24'h010001);
        for (int k = 0; k < 4; k++) begin
            u.xfer(lprm_pkg::FC_WRITE1, 16'h80a0, 16'(k));
            chk({u.last.exc, 6'h0, origin}, k == 3 ? 16'h0302 : 16'(k));
        end
        for (int k = 1; k < 4; k++) begin
            u.xfer(lprm_pkg::FC_WRITE1, 16'h8010, 16'(k));
            chk({u.last.exc, reload, lock, origin}, k == 3 ? 13'h0060 : k == 1 ? 13'h0c : 13'h10);
        end
        conclude();
    end
endmodule // test_lprm_regs
